/* core/dmc_pkg.sv */
// Constants, field positions and carrier types of the data-memory block.
// Assumes a single clock domain shared by the core and its peripherals.
package dmc_pkg;

    // ------------------------------------------------------------------
    // Sizes, address map, reset values, fields and populated pages
    // ------------------------------------------------------------------
    localparam int RAM_DEPTH = 256;
    localparam int REC_W     = 32;
    localparam int REC_CNT_W = 6;

    localparam logic [7:0] UPPER_BASE    = 8'h80;
    localparam logic [7:0] BIT_AREA_BASE = 8'h20;
    localparam logic [7:0] SP_ADDR       = 8'h81;
    localparam logic [7:0] PAGE_SEL_ADDR = 8'h84;
    localparam logic [7:0] PAGE_MID_ADDR = 8'h85;
    localparam logic [7:0] PAGE_BOT_ADDR = 8'h86;
    localparam logic [7:0] PAGE_CTL_ADDR = 8'h96;

    localparam logic [7:0] SP_RESET       = 8'h07;
    localparam logic [7:0] PAGE_RESET     = 8'h00;
    localparam logic [7:0] PAGE_CTL_RESET = 8'h01;

    localparam int AUTO_EN_BIT = 0;
    localparam int BANK_LO_BIT = 3;
    localparam int BANK_HI_BIT = 4;

    localparam logic [7:0] PAGE_0 = 8'h00;
    localparam logic [7:0] PAGE_1 = 8'h01;
    localparam logic [7:0] PAGE_2 = 8'h02;
    localparam logic [7:0] PAGE_3 = 8'h03;
    localparam logic [7:0] PAGE_F = 8'h0f;

    // ------------------------------------------------------------------
    // Carrier types
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        STK_NONE = 3'b000,
        STK_PUSH = 3'b001,
        STK_POP  = 3'b010,
        STK_CALL = 3'b011,
        STK_RET  = 3'b100
    } dmc_stk_op_type;

    typedef struct packed {
        logic       valid;
        logic       write;
        logic       indirect;
        logic       bit_op;
        logic       ptr_sel;
        logic [7:0] addr;
        logic [7:0] wdata;
    } dmc_acc_type;

    typedef struct packed {
        logic       valid;
        logic       write;
        logic       bit_op;
        logic [2:0] bit_pos;
        logic [7:0] addr;
        logic [7:0] page;
        logic [7:0] wdata;
    } dmc_sfr_type;

endpackage

/* core/dmc_core.sv */
// Internal data memory, stack, stack record and register paging.
// Assumes the core issues at most one request per cycle while ACC_READY,
// and that peripheral registers answer reads within the cycle.
//
// What this block does
// [RQ1] 256 bytes of RAM at 0x00 to 0xFF
// [RQ2] Lower half reachable direct and indirect
// [RQ3] Direct above 0x7F goes to registers
// [RQ4] Indirect above 0x7F goes to upper RAM
// [RQ5] Four banks of eight, chosen by status bits
// [RQ6] Indirect pointer from bank register zero or one
// [RQ7] Bytes 0x20-0x2F also 128 addressable bits
// [RQ8] Bit or byte access follows operand type
// [RQ9] Stack pointer increments before push write
// [RQ10] Reset sets stack pointer to 0x07
// [RQ11] 32-bit record shifts one or two bits
// [RQ12] Record overflow and underflow flagged to debug
// [RQ13] Only registers at x0 or x8 take bits
// [RQ14] Software avoids unoccupied register addresses
// [RQ15] Register address decoded with 8-bit page
// [RQ16] Only pages 0, 1, 2, 3, F populated
// [RQ17] Software selects page before direct move
// [RQ18] Interrupt entry loads the flag's page
// [RQ19] Entry pushes current to middle, middle to bottom
// [RQ20] Return pops; bottom refills with 0x00
// [RQ21] Software stack writes never push or pop
// [RQ22] Auto page enable set by reset
// [RQ23] Auto disabled: no switch, push or pop
// [RQ24] Entry push overwrites bottom contents
// [RQ25] Shared registers decode on every page
// [RQ26] Page write affects the next access
`timescale 1ns/10ps
`default_nettype none

module dmc_core
    import dmc_pkg::*;
(
    // Clock and reset
    input  wire logic           CLK,
    input  wire logic           RESET,
    // Data access from the core
    input  wire dmc_acc_type    ACC,
    input  wire logic [7:0]     PROGRAM_STATUS_WORD,
    output logic                ACC_READY,
    // Stack operations
    input  wire dmc_stk_op_type STK_OP,
    input  wire logic [15:0]    STK_WDATA,
    // Read answer
    output logic                RD_VALID,
    output logic [15:0]         RD_DATA,
    // Interrupt entry and return
    input  wire logic           INT_ENTRY,
    input  wire logic [7:0]     INT_PAGE,
    input  wire logic           INT_RETURN,
    // Peripheral register side
    output dmc_sfr_type         SFR_REQ,
    input  wire logic [7:0]     SFR_RDATA,
    // State views
    output logic [7:0]          STACK_POINTER,
    output logic [7:0]          PAGE_SELECTOR,
    // Debug stack record
    input  wire logic           REC_CLEAR,
    output logic [REC_W-1:0]    REC_DATA,
    output logic [REC_CNT_W-1:0] REC_DEPTH,
    output logic                REC_OVERFLOW,
    output logic                REC_UNDERFLOW
);

    // ------------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------------
    logic [7:0]           ram_q [RAM_DEPTH];
    logic [7:0]           stack_pointer_q;
    logic [7:0]           page_selector_q;
    logic [7:0]           page_stack_middle_q;
    logic [7:0]           page_stack_bottom_q;
    logic [7:0]           page_control_register_q;
    logic [REC_W-1:0]     rec_q;
    logic [REC_CNT_W-1:0] rec_cnt_q;
    logic                 rec_ovf_q;
    logic                 rec_unf_q;
    logic                 rd_valid_q;
    logic [15:0]          rd_data_q;
    logic                 sfr_pend_q;
    dmc_sfr_type          sfr_q;

    // ------------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------------
    logic [1:0]  bank_sel;
    logic [7:0]  ptr_addr;
    logic [7:0]  eff_addr;
    logic [2:0]  bit_pos;
    logic        ready;
    logic        stk_take;
    logic        acc_take;
    logic        to_sfr;
    logic        shared_hit;
    logic        ext_sfr;
    logic        auto_page_enable;
    logic [7:0]  int_rdata;
    logic [7:0]  ram_byte;
    logic [7:0]  sp_plus1;
    logic [7:0]  sp_plus2;
    logic [7:0]  sp_minus1;

    assign ready    = !sfr_pend_q;
    assign stk_take = ready && (STK_OP != STK_NONE);
    assign acc_take = ready && ACC.valid && (STK_OP == STK_NONE);
    assign auto_page_enable = page_control_register_q[AUTO_EN_BIT];

    assign bank_sel = {PROGRAM_STATUS_WORD[BANK_HI_BIT],
                       PROGRAM_STATUS_WORD[BANK_LO_BIT]}; // see [RQ5]
    assign ptr_addr = {3'b000, bank_sel, 2'b00, ACC.ptr_sel}; // see [RQ6]
    assign bit_pos  = ACC.addr[2:0];

    assign sp_plus1  = stack_pointer_q + 8'h01;
    assign sp_plus2  = stack_pointer_q + 8'h02;
    assign sp_minus1 = stack_pointer_q - 8'h01;

    always_comb begin
        if (ACC.indirect) begin
            eff_addr = ram_q[ptr_addr]; // see [RQ4] see [RQ2]
        end else if (ACC.bit_op) begin // see [RQ8]
            if (ACC.addr[7]) begin
                // Bit space above 0x7F only lands on x0/x8. see [RQ13]
                eff_addr = {ACC.addr[7:3], 3'b000};
            end else begin
                eff_addr = BIT_AREA_BASE | {4'h0, ACC.addr[6:3]}; // see [RQ7]
            end
        end else begin
            eff_addr = ACC.addr;
        end
    end

    assign to_sfr   = !ACC.indirect && eff_addr[7]; // see [RQ3]
    assign ram_byte = ram_q[eff_addr];

    // Shared registers ignore the page selector. see [RQ25]
    always_comb begin
        shared_hit = 1'b1;
        int_rdata  = 8'h00;
        case (eff_addr)
            SP_ADDR:       int_rdata = stack_pointer_q;
            PAGE_SEL_ADDR: int_rdata = page_selector_q;
            PAGE_MID_ADDR: int_rdata = page_stack_middle_q;
            PAGE_BOT_ADDR: int_rdata = page_stack_bottom_q;
            PAGE_CTL_ADDR: int_rdata = page_control_register_q;
            default:       shared_hit = 1'b0;
        endcase
    end

    assign ext_sfr = acc_take && to_sfr && !shared_hit;

    // Only populated pages reach the peripherals.
    logic pg_ok;

    assign pg_ok = page_selector_q inside {PAGE_0, PAGE_1, PAGE_2,
                                           PAGE_3, PAGE_F}; // see [RQ16]

    // ------------------------------------------------------------------
    // Data RAM
    // ------------------------------------------------------------------
    always_ff @(posedge CLK) begin
        if (stk_take && STK_OP == STK_PUSH) begin
            ram_q[sp_plus1] <= STK_WDATA[7:0]; // see [RQ9]
        end else if (stk_take && STK_OP == STK_CALL) begin
            ram_q[sp_plus1] <= STK_WDATA[7:0];
            ram_q[sp_plus2] <= STK_WDATA[15:8];
        end else if (acc_take && ACC.write && !to_sfr) begin // see [RQ1]
            if (ACC.bit_op) begin
                ram_q[eff_addr][bit_pos] <= ACC.wdata[0];
            end else begin
                ram_q[eff_addr] <= ACC.wdata;
            end
        end
    end

    // ------------------------------------------------------------------
    // Stack pointer
    // ------------------------------------------------------------------
    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            stack_pointer_q <= SP_RESET; // see [RQ10]
        end else if (stk_take) begin
            case (STK_OP)
                STK_PUSH: stack_pointer_q <= sp_plus1; // see [RQ9]
                STK_POP:  stack_pointer_q <= sp_minus1;
                STK_CALL: stack_pointer_q <= sp_plus2;
                STK_RET:  stack_pointer_q <= stack_pointer_q - 8'h02;
                default:  ;
            endcase
        end else if (acc_take && ACC.write && to_sfr &&
                     eff_addr == SP_ADDR && !ACC.bit_op) begin
            stack_pointer_q <= ACC.wdata;
        end
    end

    // ------------------------------------------------------------------
    // Stack record
    // ------------------------------------------------------------------
    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            rec_q     <= '0;
            rec_cnt_q <= '0;
        end else if (stk_take) begin // see [RQ11]
            case (STK_OP)
                STK_PUSH: begin
                    rec_q     <= {rec_q[REC_W-2:0], 1'b0};
                    rec_cnt_q <= (rec_cnt_q == REC_CNT_W'(REC_W)) ?
                                 rec_cnt_q : rec_cnt_q + 1'b1;
                end
                STK_CALL: begin
                    rec_q     <= {rec_q[REC_W-3:0], 2'b11};
                    rec_cnt_q <= (rec_cnt_q >= REC_CNT_W'(REC_W - 1)) ?
                                 REC_CNT_W'(REC_W) : rec_cnt_q + 2'd2;
                end
                STK_POP: begin
                    rec_q     <= {1'b0, rec_q[REC_W-1:1]};
                    rec_cnt_q <= (rec_cnt_q == '0) ?
                                 rec_cnt_q : rec_cnt_q - 1'b1;
                end
                STK_RET: begin
                    rec_q     <= {2'b00, rec_q[REC_W-1:2]};
                    rec_cnt_q <= (rec_cnt_q < REC_CNT_W'(2)) ?
                                 '0 : rec_cnt_q - 2'd2;
                end
                default: ;
            endcase
        end
    end

    // Sticky error flags; a new event wins over a clear. see [RQ12]
    logic ovf_evt;
    logic unf_evt;

    assign ovf_evt = stk_take &&
        ((STK_OP == STK_PUSH && rec_cnt_q == REC_CNT_W'(REC_W)) ||
         (STK_OP == STK_CALL && rec_cnt_q > REC_CNT_W'(REC_W - 2)));
    assign unf_evt = stk_take &&
        ((STK_OP == STK_POP && rec_cnt_q == '0) ||
         (STK_OP == STK_RET && rec_cnt_q < REC_CNT_W'(2)));

    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            rec_ovf_q <= 1'b0;
            rec_unf_q <= 1'b0;
        end else begin
            rec_ovf_q <= ovf_evt || (rec_ovf_q && !REC_CLEAR);
            rec_unf_q <= unf_evt || (rec_unf_q && !REC_CLEAR);
        end
    end

    // ------------------------------------------------------------------
    // Page control
    // ------------------------------------------------------------------
    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            page_control_register_q <= PAGE_CTL_RESET; // see [RQ22]
        end else if (acc_take && ACC.write && to_sfr &&
                     eff_addr == PAGE_CTL_ADDR && !ACC.bit_op) begin
            page_control_register_q <= ACC.wdata;
        end
    end

    // ------------------------------------------------------------------
    // Page stack
    // ------------------------------------------------------------------
    logic sw_wr;

    assign sw_wr = acc_take && ACC.write && to_sfr && !ACC.bit_op;

    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            page_selector_q     <= PAGE_RESET;
            page_stack_middle_q <= PAGE_RESET;
            page_stack_bottom_q <= PAGE_RESET;
        end else if (INT_ENTRY && auto_page_enable) begin // see [RQ23]
            page_selector_q     <= INT_PAGE;            // see [RQ18]
            page_stack_middle_q <= page_selector_q;     // see [RQ19]
            page_stack_bottom_q <= page_stack_middle_q; // see [RQ24]
        end else if (INT_RETURN && auto_page_enable) begin
            page_selector_q     <= page_stack_middle_q; // see [RQ20]
            page_stack_middle_q <= page_stack_bottom_q;
            page_stack_bottom_q <= PAGE_RESET;
        end else if (sw_wr) begin
            // Plain stores, the stack does not move. see [RQ21]
            if (eff_addr == PAGE_SEL_ADDR) begin
                page_selector_q <= ACC.wdata; // see [RQ26]
            end
            if (eff_addr == PAGE_MID_ADDR) begin
                page_stack_middle_q <= ACC.wdata;
            end
            if (eff_addr == PAGE_BOT_ADDR) begin
                page_stack_bottom_q <= ACC.wdata;
            end
        end
    end

    // ------------------------------------------------------------------
    // Peripheral register request
    // ------------------------------------------------------------------
    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            sfr_q      <= '0;
            sfr_pend_q <= 1'b0;
        end else begin
            // Page sampled as it stands now. see [RQ15] see [RQ17]
            sfr_q <= '{ext_sfr && pg_ok, ACC.write, ACC.bit_op, bit_pos,
                       eff_addr, page_selector_q, ACC.wdata};
            sfr_pend_q    <= ext_sfr && !ACC.write;
        end
    end

    // ------------------------------------------------------------------
    // Read answer
    // ------------------------------------------------------------------
    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            rd_valid_q <= 1'b0;
            rd_data_q  <= '0;
        end else if (sfr_pend_q) begin
            // Unpopulated pages read as zero.
            rd_valid_q <= 1'b1;
            if (!sfr_q.valid) begin
                rd_data_q <= '0;
            end else if (sfr_q.bit_op) begin
                rd_data_q <= {15'h0000, SFR_RDATA[sfr_q.bit_pos]};
            end else begin
                rd_data_q <= {8'h00, SFR_RDATA};
            end
        end else if (stk_take && STK_OP == STK_POP) begin
            rd_valid_q <= 1'b1;
            rd_data_q  <= {8'h00, ram_q[stack_pointer_q]};
        end else if (stk_take && STK_OP == STK_RET) begin
            rd_valid_q <= 1'b1;
            rd_data_q  <= {ram_q[stack_pointer_q], ram_q[sp_minus1]};
        end else if (acc_take && !ACC.write && !ext_sfr) begin
            rd_valid_q <= 1'b1;
            if (to_sfr) begin
                rd_data_q <= {8'h00, int_rdata};
            end else if (ACC.bit_op) begin
                rd_data_q <= {15'h0000, ram_byte[bit_pos]};
            end else begin
                rd_data_q <= {8'h00, ram_byte};
            end
        end else begin
            rd_valid_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign ACC_READY     = ready;
    assign RD_VALID      = rd_valid_q;
    assign RD_DATA       = rd_data_q;
    assign SFR_REQ       = sfr_q;
    assign STACK_POINTER = stack_pointer_q;
    assign PAGE_SELECTOR = page_selector_q;
    assign REC_DATA      = rec_q;
    assign REC_DEPTH     = rec_cnt_q;
    assign REC_OVERFLOW  = rec_ovf_q;
    assign REC_UNDERFLOW = rec_unf_q;

endmodule

`default_nettype wire

/* tb/dmc_periph_model.sv */
// Peripheral register side of the data-memory block, behavioural.
// Assumes one clock shared with the block and an active-high reset.
`timescale 1ns/10ps
`default_nettype none

module dmc_periph_model
    import dmc_pkg::*;
(
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        reset,
    // Register requests and read answer
    input  wire dmc_sfr_type sfr_req,
    output logic [7:0]       sfr_rdata
);
    logic [7:0] idle_q;

    // Outside a read the bus shows a byte that changes every cycle.
    always_ff @(posedge clk or posedge reset) begin
        if (reset)
            idle_q <= 8'h00;
        else
            idle_q <= idle_q + 8'h5b;
    end

    // Each address and page answers with its own byte.
    assign sfr_rdata = (sfr_req.valid && !sfr_req.write) ?
        (sfr_req.addr ^ sfr_req.page ^ 8'h3c) : idle_q;
endmodule

`default_nettype wire

/* tb/dmc_core_sva.sv */
// Port-level checks of the data-memory block, bound onto dmc_core.
// Assumes the single clock and the active-high asynchronous reset.
`timescale 1ns/10ps
`default_nettype none

module dmc_core_sva
    import dmc_pkg::*;
(
    // Clock and reset
    input wire logic                 CLK,
    input wire logic                 RESET,
    // Requests
    input wire dmc_acc_type          ACC,
    input wire logic                 ACC_READY,
    input wire dmc_stk_op_type       STK_OP,
    input wire logic                 INT_ENTRY,
    input wire logic [7:0]           INT_PAGE,
    input wire logic                 INT_RETURN,
    // Answers and state
    input wire logic                 RD_VALID,
    input wire logic [15:0]          RD_DATA,
    input wire dmc_sfr_type          SFR_REQ,
    input wire logic [7:0]           SFR_RDATA,
    input wire logic [7:0]           STACK_POINTER,
    input wire logic [7:0]           PAGE_SELECTOR,
    input wire logic [REC_CNT_W-1:0] REC_DEPTH,
    input wire logic                 REC_OVERFLOW,
    input wire logic                 REC_UNDERFLOW
);
    logic take;
    logic byte_wr;
    logic sel_wr;
    logic dir_rd;
    logic auto_q;

    assign take    = ACC.valid && ACC_READY && STK_OP == STK_NONE;
    assign byte_wr = take && ACC.write && !ACC.indirect && !ACC.bit_op;
    assign sel_wr  = byte_wr && ACC.addr == PAGE_SEL_ADDR;
    assign dir_rd  = take && !ACC.write && !ACC.indirect && !ACC.bit_op
                     && ACC.addr[7] && !(ACC.addr inside {SP_ADDR,
                     PAGE_SEL_ADDR, PAGE_MID_ADDR, PAGE_BOT_ADDR,
                     PAGE_CTL_ADDR}) && PAGE_SELECTOR inside {PAGE_0,
                     PAGE_1, PAGE_2, PAGE_3, PAGE_F};

    // Mirror of the auto page enable, followed from byte writes.
    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET)
            auto_q <= PAGE_CTL_RESET[AUTO_EN_BIT];
        else if (byte_wr && ACC.addr == PAGE_CTL_ADDR)
            auto_q <= ACC.wdata[AUTO_EN_BIT];
    end

    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (RESET);

    a_sp_push_inc: assert property (
        STK_OP == STK_PUSH && ACC_READY
        |=> STACK_POINTER == $past(STACK_POINTER) + 8'h01)
        else $error("push did not advance the stack pointer by one");
    a_rec_overflow_flag: assert property (
        STK_OP == STK_CALL && ACC_READY && REC_DEPTH > 6'd31 |=> REC_OVERFLOW)
        else $error("record overflow not flagged");
    a_rec_underflow_flag: assert property (
        STK_OP == STK_POP && ACC_READY && REC_DEPTH == 6'd0 |=> REC_UNDERFLOW)
        else $error("record underflow not flagged");
    a_direct_goes_sfr: assert property (
        dir_rd |=> SFR_REQ.valid && SFR_REQ.addr == $past(ACC.addr)
        && SFR_REQ.page == $past(PAGE_SELECTOR))
        else $error("direct upper read not sent to registers on its page");
    a_indirect_stays_ram: assert property (
        take && ACC.indirect && !ACC.write |=> RD_VALID && !SFR_REQ.valid)
        else $error("indirect read left the RAM");
    a_sfr_read_answer: assert property (
        SFR_REQ.valid && !SFR_REQ.write && !SFR_REQ.bit_op |-> !ACC_READY
        ##1 RD_VALID && ACC_READY && RD_DATA[7:0] == $past(SFR_RDATA))
        else $error("register read answer wrong or late");
    a_entry_loads_page: assert property (
        INT_ENTRY && auto_q |=> PAGE_SELECTOR == $past(INT_PAGE))
        else $error("interrupt entry did not load the page");
    a_auto_off_holds: assert property (
        (INT_ENTRY || INT_RETURN) && !auto_q && !sel_wr
        |=> $stable(PAGE_SELECTOR))
        else $error("page moved with automatic paging off");
    a_page_hold_idle: assert property (
        !INT_ENTRY && !INT_RETURN && !sel_wr |=> $stable(PAGE_SELECTOR))
        else $error("page selector moved without cause");

    c_indirect_read: cover property (take && ACC.indirect && !ACC.write);
    c_sfr_read: cover property (SFR_REQ.valid && !SFR_REQ.write);
    c_auto_entry: cover property (INT_ENTRY && auto_q);
endmodule

bind dmc_core dmc_core_sva u_sva (.*);

`default_nettype wire

/* tb/tb_top.sv */
// Self-checking bench of the data-memory block and its register paging.
// Assumes the peripheral model answers register reads in the same cycle.
`timescale 1ns/10ps
`default_nettype none

module tb_top
    import dmc_pkg::*;
;
    logic                 clk;
    logic                 reset;
    dmc_acc_type          acc;
    dmc_stk_op_type       stk_op;
    dmc_sfr_type          sfr_req;
    logic [7:0]           program_status_word, int_page, sfr_rdata, sp, page_sel;
    logic                 acc_ready, rd_valid, int_entry, int_return;
    logic                 rec_clear, rec_ovf, rec_unf;
    logic [15:0]          stk_wdata, rd_data, v;
    logic [REC_W-1:0]     rec_data;
    logic [REC_CNT_W-1:0] rec_depth;
    logic [7:0]           bits [3] = '{8'h00, 8'h13, 8'h7f};
    logic [7:0]           pages [5] = '{PAGE_0, PAGE_1, PAGE_2, PAGE_3, PAGE_F};
    int                   fails = 0;
    int                   tests_run = 0;

    dmc_core uut (
        .CLK(clk), .RESET(reset), .ACC(acc), .PROGRAM_STATUS_WORD(program_status_word),
        .ACC_READY(acc_ready), .STK_OP(stk_op), .STK_WDATA(stk_wdata),
        .RD_VALID(rd_valid), .RD_DATA(rd_data), .INT_ENTRY(int_entry),
        .INT_PAGE(int_page), .INT_RETURN(int_return), .SFR_REQ(sfr_req),
        .SFR_RDATA(sfr_rdata), .STACK_POINTER(sp), .PAGE_SELECTOR(page_sel),
        .REC_CLEAR(rec_clear), .REC_DATA(rec_data), .REC_DEPTH(rec_depth),
        .REC_OVERFLOW(rec_ovf), .REC_UNDERFLOW(rec_unf));
    dmc_periph_model u_periph (.clk(clk), .reset(reset), .sfr_req(sfr_req),
                               .sfr_rdata(sfr_rdata));

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    // -------------------------------------------------------------------
    // Access tasks, each entered and left at a falling edge
    // -------------------------------------------------------------------
    task automatic check(input string name, input logic [15:0] e, g);
        tests_run++;
        if (g !== e) begin
            fails++;
            $display("BAD %s expected %h seen %h", name, e, g);
        end
    endtask

    task automatic issue(input logic w, ind, bo, ps, input logic [7:0] a, d);
        int n;
        @(negedge clk);
        for (n = 0; n < 4 && acc_ready !== 1'b1; n++)
            @(negedge clk);
        acc = '{1'b1, w, ind, bo, ps, a, d};
        @(negedge clk);
        acc.valid = 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, d);
        issue(1'b1, 1'b0, 1'b0, 1'b0, a, d);
    endtask

    task automatic rd(input logic ind, bo, ps, input logic [7:0] a, e);
        int n;
        issue(1'b0, ind, bo, ps, a, 8'h00);
        for (n = 0; n < 3 && rd_valid !== 1'b1; n++)
            @(negedge clk);
        v = (rd_valid === 1'b1) ? rd_data : 16'hxxxx;
        check($sformatf("read %h", a), {8'h00, e},
              bo ? {15'h0000, v[0]} : {8'h00, v[7:0]});
    endtask

    task automatic stk(input dmc_stk_op_type op, input logic [15:0] d);
        @(negedge clk);
        stk_op = op;
        stk_wdata = d;
        @(negedge clk);
        stk_op = STK_NONE;
        v = rd_data;
    endtask

    task automatic irq(input logic ent, input logic [7:0] p);
        @(negedge clk);
        int_entry = ent;
        int_return = !ent;
        int_page = p;
        @(negedge clk);
        int_entry = 1'b0;
        int_return = 1'b0;
    endtask

    task automatic pst(input logic [7:0] s, m, b);
        check("page selector", {8'h00, s}, {8'h00, page_sel});
        rd(1'b0, 1'b0, 1'b0, PAGE_MID_ADDR, m);
        rd(1'b0, 1'b0, 1'b0, PAGE_BOT_ADDR, b);
    endtask

    task automatic print_verdict;
        $display("Comparisons %0d, mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    initial begin
        repeat (5000) @(posedge clk);
        fails++;
        print_verdict;
    end

    initial begin
        reset = 1'b1;
        acc = '0;
        program_status_word = 8'h00;
        stk_op = STK_NONE;
        stk_wdata = 16'h0000;
        {int_entry, int_return, int_page, rec_clear} = '0;
        repeat (6) @(posedge clk);
        @(negedge clk);
        reset = 1'b0;
        check("stack pointer", 16'h0007, {8'h00, sp});
        rd(1'b0, 1'b0, 1'b0, PAGE_CTL_ADDR, 8'h01);
        for (int b = 0; b < 4; b++) begin
            program_status_word = 8'(b << BANK_LO_BIT);
            wr(8'(b * 8), 8'(8'h30 + b));
            issue(1'b1, 1'b1, 1'b0, 1'b0, 8'h00, 8'(8'h40 + b));
            rd(1'b0, 1'b0, 1'b0, 8'(8'h30 + b), 8'(8'h40 + b));
        end
        wr(8'h19, 8'hc0);
        issue(1'b1, 1'b1, 1'b0, 1'b1, 8'h00, 8'h3c);
        rd(1'b1, 1'b0, 1'b1, 8'h00, 8'h3c);
        rd(1'b0, 1'b0, 1'b0, 8'hc0, 8'hfc);
        foreach (bits[i]) begin
            wr(8'h20 | 8'(bits[i][6:3]), 8'h00);
            issue(1'b1, 1'b0, 1'b1, 1'b0, bits[i], 8'h01);
            rd(1'b0, 1'b0, 1'b0, 8'h20 | 8'(bits[i][6:3]),
               8'h01 << bits[i][2:0]);
            rd(1'b0, 1'b1, 1'b0, bits[i], 8'h01);
        end
        stk(STK_PUSH, 16'h0011);
        rd(1'b0, 1'b0, 1'b0, 8'h08, 8'h11);
        stk(STK_CALL, 16'hbeef);
        check("record", 16'h0003, {13'h0000, rec_data[2:0]});
        stk(STK_RET, 16'h0000);
        check("return pair", 16'hbeef, v);
        stk(STK_POP, 16'h0000);
        check("pop byte", 16'h0011, {8'h00, v[7:0]});
        stk(STK_POP, 16'h0000);
        check("underflow", 16'h0001, {15'h0000, rec_unf});
        check("stack pointer", 16'h0006, {8'h00, sp});
        @(negedge clk);
        rec_clear = 1'b1;
        @(negedge clk);
        rec_clear = 1'b0;
        wr(SP_ADDR, 8'h50);
        check("stack pointer", 16'h0050, {8'h00, sp});
        repeat (17) stk(STK_CALL, 16'h1234);
        check("depth", 16'h0020, {10'h000, rec_depth});
        check("overflow", 16'h0001, {15'h0000, rec_ovf});
        foreach (pages[i]) begin
            wr(PAGE_SEL_ADDR, pages[i]);
            rd(1'b0, 1'b0, 1'b0, 8'hc0, 8'hfc ^ pages[i]);
        end
        wr(PAGE_SEL_ADDR, 8'h05);
        rd(1'b0, 1'b0, 1'b0, 8'hc0, 8'h00);
        rd(1'b0, 1'b0, 1'b0, SP_ADDR, 8'h72);
        wr(PAGE_SEL_ADDR, PAGE_F);
        irq(1'b1, PAGE_2);
        pst(PAGE_2, PAGE_F, 8'h00);
        wr(PAGE_BOT_ADDR, 8'h33);
        pst(PAGE_2, PAGE_F, 8'h33);
        irq(1'b1, PAGE_0);
        pst(PAGE_0, PAGE_2, PAGE_F);
        irq(1'b0, 8'h00);
        pst(PAGE_2, PAGE_F, 8'h00);
        irq(1'b0, 8'h00);
        pst(PAGE_F, 8'h00, 8'h00);
        wr(PAGE_CTL_ADDR, 8'h00);
        irq(1'b1, PAGE_3);
        irq(1'b0, 8'h00);
        pst(PAGE_F, 8'h00, 8'h00);
        print_verdict;
    end
endmodule

`default_nettype wire
